/* verilog/ssm_pkg.sv */
// package for the servo sequence monitor: register map, resets, types
// assumes a single 200 MHz clock and a plain word-indexed register port
package ssm_pkg;

  // clock and ramp timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned RAMP_UNIT_NS  = 2000; // 2 ms per 1000 r/min
  localparam int unsigned RAMP_UNIT_CYC =
    (RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register indices
  localparam logic [4:0] REG_JOG_SPEED     = 5'h00;
  localparam logic [4:0] REG_SOFT_ACCEL    = 5'h01;
  localparam logic [4:0] REG_SOFT_DECEL    = 5'h02;
  localparam logic [4:0] REG_MAX_TORQUE    = 5'h03;
  localparam logic [4:0] REG_INPOS_RANGE   = 5'h04;
  localparam logic [4:0] REG_ZERO_LEVEL    = 5'h05;
  localparam logic [4:0] REG_ROT_LEVEL     = 5'h06;
  localparam logic [4:0] REG_OVF_LEVEL     = 5'h07;
  localparam logic [4:0] REG_OVF_DISABLE   = 5'h08;
  localparam logic [4:0] REG_PROHIBIT_SEL  = 5'h09;
  localparam logic [4:0] REG_ALARM_SEL     = 5'h0a;
  localparam logic [4:0] REG_PRESET0       = 5'h0b; // 0x0b..0x0e
  localparam logic [4:0] REG_CTRL_MODE     = 5'h0f;
  localparam logic [4:0] REG_TORQUE_SWITCH = 5'h10;
  localparam logic [4:0] REG_WARN_SELECT   = 5'h11;
  localparam logic [4:0] REG_STATUS        = 5'h12;
  localparam logic [4:0] REG_DEV_LO        = 5'h13;
  localparam logic [4:0] REG_DEV_HI        = 5'h14;

  // reset values
  localparam logic [15:0] RST_JOG_SPEED   = 16'h00c8;
  localparam logic [15:0] RST_SOFT_TIME   = 16'h0000;
  localparam logic [15:0] RST_MAX_TORQUE  = 16'h012c;
  localparam logic [15:0] RST_INPOS_RANGE = 16'h0019;
  localparam logic [15:0] RST_ZERO_LEVEL  = 16'h0014;
  localparam logic [15:0] RST_ROT_LEVEL   = 16'h0032;
  localparam logic [15:0] RST_OVF_LEVEL   = 16'h0064;
  localparam logic [15:0] RST_ZERO        = 16'h0000;

  // limits and fixed figures
  localparam logic [15:0] JOG_SPEED_MAX   = 16'h01f4;
  localparam logic [15:0] SOFT_TIME_MAX   = 16'h1388;
  localparam logic [15:0] HYST_RPM        = 16'h000a;
  localparam logic [15:0] COUNT_MAX_15    = 16'h7fff;
  localparam int unsigned OVF_SHIFT       = 8;  // x256 pulses
  localparam logic [1:0]  TORQUE_SW_NO1   = 2'h2;
  localparam logic [1:0]  WARN_ZERO_SPEED = 2'h1;

  // status register bit positions
  localparam int unsigned ST_INP   = 0;
  localparam int unsigned ST_ZERO  = 1;
  localparam int unsigned ST_ROT   = 2;
  localparam int unsigned ST_OVF   = 3;
  localparam int unsigned ST_ALARM = 4;
  localparam int unsigned ST_BRAKE = 5;
  localparam int unsigned ST_FREE  = 6;
  localparam int unsigned ST_LOCK  = 7;

  typedef enum logic [1:0] {
    SSM_MODE_POSITION  = 2'b00,
    SSM_MODE_INT_SPEED = 2'b01
  } ssm_mode_type;

  typedef enum logic [1:0] {
    SSM_ALM_RUN   = 2'b00,
    SSM_ALM_DECEL = 2'b01,
    SSM_ALM_STOP  = 2'b10
  } ssm_alm_type;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ssm_bus_type;

endpackage

/* verilog/ssm_top.sv */
// servo sequence monitor: presets, jog, ramp, torque limit, detectors,
// deviation counter with overflow alarm, prohibit and alarm stop
// assumes inputs synchronous to clock; speed feedback in signed r/min
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps

module ssm_top #(
  parameter logic [15:0] TORQUE_LIMIT2 = 16'h0064
) (
  input  wire logic                clock,
  input  wire logic                rstn,
  input  wire ssm_pkg::ssm_bus_type bus,
  output      logic [15:0]         rdata,
  input  wire logic                power_cycle,
  input  wire logic [1:0]          preset_sel,
  input  wire logic                jog_req,
  input  wire logic                jog_reverse,
  input  wire logic                limit_sel,
  input  wire logic signed [15:0]  motor_speed,
  input  wire logic                enc_a,
  input  wire logic                enc_b,
  input  wire logic                cmd_pulse,
  input  wire logic                cmd_reverse,
  input  wire logic                forward_prohibit_in,
  input  wire logic                reverse_prohibit_in,
  input  wire logic                alarm_in,
  input  wire logic                alarm_reset,
  output      logic signed [15:0]  speed_ref,
  output      logic [15:0]         torque_limit_fwd,
  output      logic [15:0]         torque_limit_rev,
  output      logic                dyn_brake_out,
  output      logic                servo_free_out,
  output      logic                servo_lock_out,
  output      logic                positioning_done_out,
  output      logic                zero_speed_out,
  output      logic                rotation_detect_out,
  output      logic                overflow_alarm_out
);
  import ssm_pkg::*;

  // elaboration check: second limit must not exceed the accepted maximum torque cap
  if (TORQUE_LIMIT2 > RST_MAX_TORQUE) begin
    $error("second torque limit above the permitted cap");
  end

  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    mag16 = v[15] ? 16'(-v) : 16'(v);
  endfunction

  function automatic logic [31:0] mag32(input logic signed [31:0] v);
    mag32 = v[31] ? 32'(-v) : 32'(v);
  endfunction

  // software-side settings, written over the register port
  logic [15:0]        w_q [0:17];
  // active settings, copied from the written set on power cycle
  logic [15:0]        a_q [0:17];
  logic               load_q;
  logic signed [31:0] dev_q;
  logic [1:0]         enc_q;
  logic               ovf_q;
  ssm_alm_type        alm_q;
  logic signed [15:0] ramp_q;
  logic [21:0]        tick_q;
  logic               zero_raw_q;
  logic [15:0]        status;

  function automatic logic [15:0] reset_of(input int i);
    unique case (i)
      int'(REG_JOG_SPEED):   reset_of = RST_JOG_SPEED;
      int'(REG_MAX_TORQUE):  reset_of = RST_MAX_TORQUE;
      int'(REG_INPOS_RANGE): reset_of = RST_INPOS_RANGE;
      int'(REG_ZERO_LEVEL):  reset_of = RST_ZERO_LEVEL;
      int'(REG_ROT_LEVEL):   reset_of = RST_ROT_LEVEL;
      int'(REG_OVF_LEVEL):   reset_of = RST_OVF_LEVEL;
      default:               reset_of = RST_ZERO;
    endcase
  endfunction

  // write acceptance; out-of-range values are simply dropped
  function automatic logic accept(input logic [4:0] a,
                                  input logic [15:0] d);
    unique case (a)
      REG_JOG_SPEED:   accept = d <= JOG_SPEED_MAX;
      REG_SOFT_ACCEL,
      REG_SOFT_DECEL:  accept = d <= SOFT_TIME_MAX;
      REG_MAX_TORQUE:  accept = d <= RST_MAX_TORQUE;
      REG_INPOS_RANGE,
      REG_OVF_LEVEL:   accept = d <= COUNT_MAX_15;
      REG_OVF_DISABLE: accept = d <= 16'h0001;
      REG_PROHIBIT_SEL: accept = d <= 16'h0002;
      REG_ALARM_SEL:   accept = d <= 16'h0003;
      default:         accept = a < REG_STATUS;
    endcase
  endfunction

  // written settings
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 18; i++) begin
        w_q[i] <= reset_of(i);
      end
    end else if (bus.wr && accept(bus.addr, bus.wdata)) begin
      w_q[bus.addr] <= bus.wdata;
    end
  end

  // active copy on power cycle and once on the first cycle after reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      load_q <= 1'b1;
      for (int i = 0; i < 18; i++) begin
        a_q[i] <= reset_of(i);
      end
    end else begin
      load_q <= 1'b0;
      if (load_q || power_cycle) begin
        a_q <= w_q;
      end
    end
  end

  // register reads, one cycle after the strobe
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata <= 16'h0000;
    end else if (bus.rd) begin
      if (bus.addr < REG_STATUS) begin
        rdata <= w_q[bus.addr];
      end else if (bus.addr == REG_STATUS) begin
        rdata <= status;
      end else if (bus.addr == REG_DEV_LO) begin
        rdata <= dev_q[15:0];
      end else if (bus.addr == REG_DEV_HI) begin
        rdata <= dev_q[31:16];
      end else begin
        rdata <= 16'h0000;  // unmapped
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  always_comb begin
    status = 16'h0000;
    status[ST_INP]   = positioning_done_out;
    status[ST_ZERO]  = zero_speed_out;
    status[ST_ROT]   = rotation_detect_out;
    status[ST_OVF]   = ovf_q;
    status[ST_ALARM] = alm_q != SSM_ALM_RUN;
    status[ST_BRAKE] = dyn_brake_out;
    status[ST_FREE]  = servo_free_out;
    status[ST_LOCK]  = servo_lock_out;
  end

  wire logic alarm_any = alarm_in | ovf_q;
  wire logic int_speed = a_q[REG_CTRL_MODE][1:0] == SSM_MODE_INT_SPEED;
  wire logic [15:0] speed_mag = mag16(motor_speed);
  wire logic [15:0] psel = a_q[REG_PROHIBIT_SEL];
  // prohibit inputs taken directly, whatever the direction of motion
  wire logic fwd_block = forward_prohibit_in;
  wire logic rev_block = reverse_prohibit_in;
  wire logic prohibit  = fwd_block | rev_block;

  // x4 quadrature step from gray transitions
  logic signed [1:0] enc_step;
  always_comb begin
    unique case ({enc_q, enc_a, enc_b})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: enc_step = 2'sd1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: enc_step = -2'sd1;
      default:                            enc_step = 2'sd0;
    endcase
  end

  // deviation: command pulses minus feedback counts
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      enc_q <= 2'b00;
      dev_q <= 32'sd0;
    end else begin
      enc_q <= {enc_a, enc_b};
      // hold on alarm, clear on reset
      if (alarm_reset && !alarm_in) begin
        dev_q <= 32'sd0;
      end else if (alm_q == SSM_ALM_RUN && !alarm_any) begin
        dev_q <= dev_q + 32'(enc_step == 2'sd0 ? 0 : -int'(enc_step))
               + (cmd_pulse ? (cmd_reverse ? -32'sd1 : 32'sd1) : 32'sd0);
      end
    end
  end

  wire logic [31:0] dev_mag = mag32(dev_q);
  wire logic [31:0] ovf_lim = {16'h0000, a_q[REG_OVF_LEVEL]} << OVF_SHIFT;

  // overflow alarm; a new overflow wins over the reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ovf_q <= 1'b0;
    end else if (a_q[REG_OVF_DISABLE][0]) begin
      ovf_q <= 1'b0;
    end else if (dev_mag >= ovf_lim) begin
      ovf_q <= 1'b1;
    end else if (alarm_reset) begin
      ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      positioning_done_out <= 1'b0;
      overflow_alarm_out   <= 1'b0;
    end else begin
      positioning_done_out <= dev_mag < {16'h0000, a_q[REG_INPOS_RANGE]};
      overflow_alarm_out   <= ovf_q;
    end
  end

  // detectors with hysteresis; raw flag also tracks standstill
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      zero_raw_q          <= 1'b1;
      zero_speed_out      <= 1'b0;
      rotation_detect_out <= 1'b0;
    end else begin
      // on below level, off at level plus 10
      if (speed_mag < a_q[REG_ZERO_LEVEL]) begin
        zero_raw_q <= 1'b1;
      end else if (speed_mag >= a_q[REG_ZERO_LEVEL] + HYST_RPM) begin
        zero_raw_q <= 1'b0;
      end
      zero_speed_out <= zero_raw_q &&
        a_q[REG_WARN_SELECT][1:0] == WARN_ZERO_SPEED;
      // on above level, off below level minus 10
      if (speed_mag > a_q[REG_ROT_LEVEL]) begin
        rotation_detect_out <= 1'b1;
      end else if (speed_mag + HYST_RPM < a_q[REG_ROT_LEVEL]) begin
        rotation_detect_out <= 1'b0;
      end
    end
  end

  // alarm stop sequence: decelerate, then standstill
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alm_q <= SSM_ALM_RUN;
    end else begin
      unique case (alm_q)
        SSM_ALM_RUN:   if (alarm_any) alm_q <= SSM_ALM_DECEL;
        SSM_ALM_DECEL: if (zero_raw_q) alm_q <= SSM_ALM_STOP;
        SSM_ALM_STOP:  if (alarm_reset && !alarm_any) alm_q <= SSM_ALM_RUN;
        default:       alm_q <= SSM_ALM_RUN;
      endcase
    end
  end

  // speed target: jog first, then presets in internal speed mode
  logic signed [15:0] target;
  always_comb begin
    if (jog_req) begin
      target = jog_reverse ? 16'(-$signed(a_q[REG_JOG_SPEED]))
                           : $signed(a_q[REG_JOG_SPEED]);
    end else if (int_speed) begin
      target = $signed(a_q[REG_PRESET0 + 5'(preset_sel)]);
    end else begin
      target = 16'sd0;
    end
    if (alm_q != SSM_ALM_RUN || (prohibit && psel == 16'h0002)) begin
      target = 16'sd0;
    end
  end

  // decelerating when heading toward zero or reversing
  wire logic decel = target == 16'sd0 || target[15] != ramp_q[15] ||
                     mag16(target) < mag16(ramp_q);
  wire logic [15:0] ramp_set = decel ? a_q[REG_SOFT_DECEL]
                                     : a_q[REG_SOFT_ACCEL];
  // cycles per 1 r/min step; 5000 x 400 still fits 22 bits
  wire logic [21:0] ramp_per = 22'(ramp_set) * 22'(RAMP_UNIT_CYC);

  // one r/min per setting x 2 us
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ramp_q <= 16'sd0;
      tick_q <= 22'h000000;
    end else if (ramp_q == target) begin
      tick_q <= 22'h000000;
    end else if (ramp_per == 22'h000000) begin
      ramp_q <= target;
    end else if (tick_q >= ramp_per - 22'h000001) begin
      tick_q <= 22'h000000;
      ramp_q <= (target > ramp_q) ? ramp_q + 16'sd1 : ramp_q - 16'sd1;
    end else begin
      tick_q <= tick_q + 22'h000001;
    end
  end

  // speed reference follows the ramp only in speed-type operation
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      speed_ref <= 16'sd0;
    end else begin
      speed_ref <= (int_speed || jog_req) ? ramp_q : 16'sd0;
    end
  end

  // torque cap, selected limit, prohibit and alarm masking
  wire logic [15:0] cap = (a_q[REG_TORQUE_SWITCH][1:0] == TORQUE_SW_NO1
                           && limit_sel) ? TORQUE_LIMIT2
                                         : a_q[REG_MAX_TORQUE];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      torque_limit_fwd <= 16'h0000;
      torque_limit_rev <= 16'h0000;
    end else begin
      torque_limit_fwd <= cap;
      torque_limit_rev <= cap;
      if (alm_q != SSM_ALM_RUN || (fwd_block && psel != 16'h0002)) begin
        torque_limit_fwd <= 16'h0000;
      end
      if (alm_q != SSM_ALM_RUN || (rev_block && psel != 16'h0002)) begin
        torque_limit_rev <= 16'h0000;
      end
    end
  end

  // stop actions; an alarm outranks a prohibit input
  wire logic [1:0] asel = a_q[REG_ALARM_SEL][1:0];
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dyn_brake_out  <= 1'b0;
      servo_free_out <= 1'b0;
      servo_lock_out <= 1'b0;
    end else if (alm_q != SSM_ALM_RUN) begin
      // bit0 coast in decel, bit1 free at rest
      dyn_brake_out  <= alm_q == SSM_ALM_DECEL ? !asel[0] : !asel[1];
      servo_free_out <= alm_q == SSM_ALM_DECEL ? asel[0] : asel[1];
      servo_lock_out <= 1'b0;
    end else begin
      dyn_brake_out  <= prohibit && psel == 16'h0000;
      servo_free_out <= prohibit && psel == 16'h0001;
      servo_lock_out <= prohibit && psel == 16'h0002 && !int_speed;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_alarm_enter;
    alm_q == SSM_ALM_RUN ##1 alm_q == SSM_ALM_DECEL;
  endsequence
  // a reset inside the window may legally clear the count
  sequence s_no_reset;
    !alarm_reset [*3];
  endsequence

  property p_dev_freeze;
    s_alarm_enter ##0 s_no_reset |=> dev_q == $past(dev_q, 3);
  endproperty
  a_dev_freeze: assert property (p_dev_freeze)
    else $error("deviation moved during alarm");

  property p_dev_clear;
    alarm_reset && !alarm_in |=> dev_q == 32'sd0;
  endproperty
  a_dev_clear: assert property (p_dev_clear)
    else $error("deviation not cleared by alarm reset");

  property p_inp;
    dev_mag < {16'h0000, a_q[REG_INPOS_RANGE]} |=> positioning_done_out;
  endproperty
  a_inp: assert property (p_inp)
    else $error("positioning done missing");

  property p_inp_off;
    dev_mag >= {16'h0000, a_q[REG_INPOS_RANGE]} |=> !positioning_done_out;
  endproperty
  a_inp_off: assert property (p_inp_off)
    else $error("positioning done above range");

  property p_ovf_off;
    a_q[REG_OVF_DISABLE][0] |=> !ovf_q;
  endproperty
  a_ovf_off: assert property (p_ovf_off)
    else $error("overflow alarm while disabled");

  property p_ovf_set;
    !a_q[REG_OVF_DISABLE][0] && dev_mag >= ovf_lim |=> ##1 overflow_alarm_out;
  endproperty
  a_ovf_set: assert property (p_ovf_set)
    else $error("overflow alarm not raised");

  property p_torque_refuse;
    bus.wr && bus.addr == REG_MAX_TORQUE && bus.wdata > RST_MAX_TORQUE
      |=> $stable(w_q[REG_MAX_TORQUE]);
  endproperty
  a_torque_refuse: assert property (p_torque_refuse)
    else $error("torque limit above default accepted");

  property p_torque_both;
    alm_q == SSM_ALM_RUN && !prohibit |=> torque_limit_fwd == torque_limit_rev;
  endproperty
  a_torque_both: assert property (p_torque_both)
    else $error("torque limits differ");

  property p_zero_hyst;
    zero_raw_q && speed_mag < a_q[REG_ZERO_LEVEL] + HYST_RPM |=> zero_raw_q;
  endproperty
  a_zero_hyst: assert property (p_zero_hyst)
    else $error("zero speed dropped inside hysteresis");

  property p_brake_sel0;
    alm_q == SSM_ALM_RUN && !alarm_any && prohibit && psel == 16'h0000
      |=> dyn_brake_out && !servo_free_out;
  endproperty
  a_brake_sel0: assert property (p_brake_sel0)
    else $error("dynamic brake missing on prohibit");

endmodule

/* testbench/ssm_motor.sv */
// motor and encoder stand-in: quadrature phases and speed feedback
// assumes the bench pulses step once for each count of shaft travel
`timescale 1ns/1ps
module ssm_motor (
  input  wire logic               clock,
  input  wire logic               rstn,
  input  wire logic               step,
  input  wire logic               rev,
  input  wire logic signed [15:0] speed_set,
  output      logic               enc_a,
  output      logic               enc_b,
  output      logic signed [15:0] motor_speed
);
  logic [1:0] ph_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ph_q <= 2'h0;
    else if (step) ph_q <= rev ? ph_q - 2'h1 : ph_q + 2'h1;
  end
  // gray order, so only one phase moves per count
  assign enc_a = ph_q[1];
  assign enc_b = ph_q[1] ^ ph_q[0];
  // speed feedback lags the set value by a clock
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) motor_speed <= 16'sh0;
    else motor_speed <= speed_set;
  end
endmodule

/* testbench/servo_sequence_monitor_tb.sv */
// bench for the servo sequence monitor: registers, presets, jog, caps,
// detectors, deviation count, overflow, prohibit stop
// assumes ssm_motor as far side and a 200 MHz clock
`timescale 1ns/1ps
module servo_sequence_monitor_tb;
  import ssm_pkg::*;
  logic               clock = 1'b0;
  logic               rstn = 1'b0;
  ssm_bus_type        bus = '0;
  logic               power_cycle = 1'b0;
  logic [1:0]         preset_sel = 2'h0;
  logic               jog_req = 1'b0;
  logic               jog_reverse = 1'b0;
  logic               cmd_pulse = 1'b0;
  logic               fwd_p = 1'b0;
  logic               rev_p = 1'b0;
  logic               lsel = 1'b0;
  logic               alarm_in = 1'b0;
  logic               alarm_reset = 1'b0;
  logic               step = 1'b0;
  logic signed [15:0] speed_set = 16'sh0;
  logic signed [15:0] motor_speed, speed_ref;
  logic [15:0]        rdata, tq_f, tq_r, rv, rv2;
  logic               enc_a, enc_b, brake, free, lock;
  logic               done, zero, rot, ovf;
  int                 error_cnt = 0;
  int                 n_tests = 0;
  localparam logic [15:0] RST_TAB [11] = '{16'h00c8, 16'h0, 16'h0,
    16'h012c, 16'h0019, 16'h0014, 16'h0032, 16'h0064, 16'h0, 16'h0, 16'h0};

  always #2.5 clock = ~clock;

  ssm_top uut (
    .clock(clock), .rstn(rstn), .bus(bus), .rdata(rdata),
    .power_cycle(power_cycle), .preset_sel(preset_sel),
    .jog_req(jog_req), .jog_reverse(jog_reverse), .limit_sel(lsel),
    .motor_speed(motor_speed), .enc_a(enc_a), .enc_b(enc_b),
    .cmd_pulse(cmd_pulse), .cmd_reverse(1'b0),
    .forward_prohibit_in(fwd_p), .reverse_prohibit_in(rev_p),
    .alarm_in(alarm_in), .alarm_reset(alarm_reset),
    .speed_ref(speed_ref), .torque_limit_fwd(tq_f),
    .torque_limit_rev(tq_r), .dyn_brake_out(brake),
    .servo_free_out(free), .servo_lock_out(lock),
    .positioning_done_out(done), .zero_speed_out(zero),
    .rotation_detect_out(rot), .overflow_alarm_out(ovf)
  );
  ssm_motor motor (
    .clock(clock), .rstn(rstn), .step(step), .rev(1'b0),
    .speed_set(speed_set), .enc_a(enc_a), .enc_b(enc_b),
    .motor_speed(motor_speed)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // bus cycles: one strobe cycle each, read data the cycle after
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clock);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic pc;
    @(posedge clock);
    power_cycle <= 1'b1;
    @(posedge clock);
    power_cycle <= 1'b0;
    tick(3);
  endtask
  task automatic rst;
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    tick(3);
  endtask
  // command pulses spaced by an idle cycle
  task automatic cmd(input int n);
    repeat (n) begin
      @(posedge clock);
      cmd_pulse <= 1'b1;
      @(posedge clock);
      cmd_pulse <= 1'b0;
    end
    tick(4);
  endtask
  function automatic logic [15:0] pv(input int i);
    return (i % 2) ? 16'(-(i + 1) * 100) : 16'((i + 1) * 100);
  endfunction

  task automatic t_regs;
    rst;
    for (int i = 0; i < 11; i++) begin
      rd(5'(i), rv);
      chk(rv, RST_TAB[i]);
    end
    wr(REG_MAX_TORQUE, 16'h012d);
    rd(REG_MAX_TORQUE, rv);
    chk(rv, 16'h012c);
    wr(REG_MAX_TORQUE, 16'h0096);
    rd(REG_MAX_TORQUE, rv);
    chk(rv, 16'h0096);
    chk(tq_f, 16'h012c);
    pc;
    chk(tq_f, 16'h0096);
    chk(tq_r, 16'h0096);
    wr(REG_TORQUE_SWITCH, 16'h2);
    pc;
    @(posedge clock);
    lsel <= 1'b1;
    tick(3);
    chk(tq_f, 16'h0064);
    chk(tq_r, 16'h0064);
    @(posedge clock);
    lsel <= 1'b0;
    rd(5'h1f, rv);
    chk(rv, 16'h0);
  endtask
  task automatic t_presets;
    rst;
    wr(REG_CTRL_MODE, 16'h1);
    for (int i = 0; i < 4; i++) wr(REG_PRESET0 + 5'(i), pv(i));
    pc;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      preset_sel <= 2'(i);
      tick(4);
      chk(speed_ref, pv(i));
    end
    @(posedge clock);
    jog_req <= 1'b1;
    tick(4);
    chk(speed_ref, 16'h00c8);
    @(posedge clock);
    jog_reverse <= 1'b1;
    tick(4);
    chk(speed_ref, 16'hff38);
    @(posedge clock);
    jog_req <= 1'b0;
    jog_reverse <= 1'b0;
  endtask
  // speed walk through both hysteresis bands, {zero, rotation}
  task automatic t_detect;
    int          sp [8] = '{15, 25, 30, 51, 40, 39, -60, -15};
    logic [1:0]  ex [8] = '{2'h2, 2'h2, 2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h2};
    rst;
    wr(REG_WARN_SELECT, 16'h1);
    pc;
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      speed_set <= 16'(sp[i]);
      tick(4);
      chk(16'({zero, rot}), 16'(ex[i]));
    end
  endtask
  task automatic t_inpos;
    rst;
    chk(16'(done), 16'h0001);
    cmd(24);
    chk(16'(done), 16'h0001);
    cmd(1);
    chk(16'(done), 16'h0000);
    rd(REG_DEV_LO, rv);
    chk(rv, 16'h0019);
    // one full line period of both phases gives four counts
    @(posedge clock);
    step <= 1'b1;
    repeat (4) @(posedge clock);
    step <= 1'b0;
    tick(4);
    rd(REG_DEV_LO, rv2);
    chk(rv2, rv - 16'h0004);
  endtask
  task automatic t_ovf;
    rst;
    cmd(5);
    @(posedge clock);
    alarm_in <= 1'b1;
    cmd(3);
    rd(REG_DEV_LO, rv);
    chk(rv, 16'h0005);
    @(posedge clock);
    alarm_in <= 1'b0;
    @(posedge clock);
    alarm_reset <= 1'b1;
    @(posedge clock);
    alarm_reset <= 1'b0;
    tick(3);
    rd(REG_DEV_LO, rv);
    chk(rv, 16'h0);
    wr(REG_OVF_LEVEL, 16'h1);
    pc;
    cmd(255);
    chk(16'(ovf), 16'h0000);
    cmd(1);
    chk(16'(ovf), 16'h0001);
    rst;
    wr(REG_OVF_LEVEL, 16'h1);
    wr(REG_OVF_DISABLE, 16'h1);
    pc;
    cmd(300);
    chk(16'(ovf), 16'h0000);
  endtask
  // soft start to preset four, then prohibit stop in speed mode
  task automatic t_ramp;
    rst;
    wr(REG_CTRL_MODE, 16'h1);
    wr(REG_SOFT_ACCEL, 16'h1);
    wr(REG_PRESET0 + 5'h3, 16'h0005);
    wr(REG_PROHIBIT_SEL, 16'h2);
    @(posedge clock);
    preset_sel <= 2'h3;
    pc;
    tick(1000);
    chk(speed_ref, 16'h0002);
    tick(1100);
    chk(speed_ref, 16'h0005);
    @(posedge clock);
    fwd_p <= 1'b1;
    tick(4);
    chk(speed_ref, 16'h0000);
    chk(16'({lock, tq_f == 16'h0}), 16'h0000);
    @(posedge clock);
    fwd_p <= 1'b0;
  endtask
  // alarm stop modes 0..3: {decel brake, free, rest brake, free}
  task automatic t_alarm;
    logic [3:0] ex [4] = '{4'ha, 4'h6, 4'h9, 4'h5};
    for (int m = 0; m < 4; m++) begin
      rst;
      wr(REG_ALARM_SEL, 16'(m));
      pc;
      @(posedge clock);
      speed_set <= 16'sd100;
      tick(4);
      @(posedge clock);
      alarm_in <= 1'b1;
      tick(4);
      rv[3:2] = {brake, free};
      @(posedge clock);
      speed_set <= 16'sd0;
      tick(6);
      rv[1:0] = {brake, free};
      chk(16'(rv[3:0]), 16'(ex[m]));
      chk(tq_f, 16'h0000);
      @(posedge clock);
      alarm_in <= 1'b0;
    end
  endtask
  // stop modes 0..2 on a forward prohibit: {fwd off, brake, free, lock}
  task automatic t_prohibit;
    logic [3:0] ex [3] = '{4'hc, 4'ha, 4'h1};
    for (int m = 0; m < 3; m++) begin
      rst;
      wr(REG_PROHIBIT_SEL, 16'(m));
      pc;
      @(posedge clock);
      fwd_p <= 1'b1;
      tick(4);
      chk(16'({tq_f == 16'h0, brake, free, lock}), 16'(ex[m]));
      chk(tq_r, 16'h012c);
      @(posedge clock);
      fwd_p <= 1'b0;
      rev_p <= 1'b1;
      tick(4);
      chk(16'(tq_r == 16'h0), 16'(ex[m][3]));
      chk(tq_f, 16'h012c);
      @(posedge clock);
      rev_p <= 1'b0;
    end
  endtask

  // main sequence, reset held two cycles first
  initial begin
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    tick(3);
    t_regs;
    t_presets;
    t_detect;
    t_inpos;
    t_ovf;
    t_ramp;
    t_alarm;
    t_prohibit;
    close_out;
  end
  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    #200000;
    error_cnt++;
    close_out;
  end
endmodule
